// *** core/srh_cfg.svh ***
// Purpose: Constants for the status reporting hierarchy block
// Assumes: Included by its bare name, once per compilation unit
// Notes: Offsets here are bit positions within the status byte, the standard latch register and parts
`ifndef SRH_CFG_SVH
`define SRH_CFG_SVH

// Generic status register part width and the always-zero top bit
`define SRH_PART_W 16
`define SRH_PART_TOP 15
`define SRH_HW_W 15

// Status byte layout
`define SRH_STB_W 8
`define SRH_STB_ERRQ 2
`define SRH_STB_QUESTIONABLE_SUMMARY_FLAG 3
`define SRH_STB_REPLY 4
`define SRH_STB_STD 5
`define SRH_STB_MSS 6
`define SRH_STB_OPERATION_SUMMARY_FLAG 7

// Standard latch register layout (bit 1 unused)
`define SRH_STD_OPC 0
`define SRH_STD_UNUSED 1
`define SRH_STD_QUERY_ERR 2
`define SRH_STD_DEV_ERR 3
`define SRH_STD_EXEC_ERR 4
`define SRH_STD_CMD_ERR 5
`define SRH_STD_USER_REQ 6
`define SRH_STD_POWER_ON 7

// Reset values of writable parts
`define SRH_RISE_RESET 16'h7FFF
`define SRH_FALL_RESET 16'h0000
`define SRH_MASK_RESET 16'h0000
`define SRH_SRE_RESET 8'h00
`define SRH_ESE_RESET 8'h00

// Error queue geometry
`define SRH_ERRQ_DEPTH 8
`define SRH_ERRQ_AW 3
`define SRH_ERRQ_CW 4
`define SRH_ERR_W 16

`endif

// *** core/srh_pkg.sv ***
// Purpose: Types shared by the status reporting hierarchy block
// Assumes: Compiled before any module that imports it
// Notes: Command codes select which part is accessed
package srh_pkg;

  typedef enum logic [3:0] {
    SRH_OP_STB_QUERY = 4'h0,
    SRH_OP_SRE_WRITE = 4'h1,
    SRH_OP_SRE_READ = 4'h2,
    SRH_OP_STD_READ = 4'h3,
    SRH_OP_STDM_WRITE = 4'h4,
    SRH_OP_STDM_READ = 4'h5,
    SRH_OP_ERR_READ = 4'h6,
    SRH_OP_LIVE_READ = 4'h7,
    SRH_OP_RISE_WRITE = 4'h8,
    SRH_OP_RISE_READ = 4'h9,
    SRH_OP_FALL_WRITE = 4'hA,
    SRH_OP_FALL_READ = 4'hB,
    SRH_OP_LATCH_READ = 4'hC,
    SRH_OP_MASK_WRITE = 4'hD,
    SRH_OP_MASK_READ = 4'hE
  } srh_op_t;

  typedef enum logic [0:0] {
    SRH_SEL_QUESTIONABLE_SUMMARY_FLAG = 1'b0,
    SRH_SEL_OPERATION_SUMMARY_FLAG = 1'b1
  } srh_sel_t;

endpackage

// *** core/srh_status_core.sv ***
// Purpose: Status register hierarchy with service request generation
// Assumes: Status, event and queue inputs come from logic on clock
// Notes: Commands take effect in one cycle; answers follow one cycle later
`timescale 1ns/100ps
`include "srh_cfg.svh"

module srh_status_core (
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire srh_pkg::srh_op_t cmd_op,
  input wire srh_pkg::srh_sel_t cmd_sel,
  input wire logic [`SRH_PART_W-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [`SRH_PART_W-1:0] rsp_data,
  input wire logic poll_req,
  output logic poll_valid,
  output logic [`SRH_STB_W-1:0] poll_data,
  input wire logic [`SRH_HW_W-1:0] questionable_summary_flag_status,
  input wire logic [`SRH_HW_W-1:0] operation_summary_flag_status,
  input wire logic [`SRH_STB_W-1:0] std_event_set,
  input wire logic err_push,
  input wire logic [`SRH_ERR_W-1:0] err_code,
  output logic err_full,
  input wire logic reply_waiting,
  output logic [`SRH_STB_W-1:0] status_byte,
  output logic service_request
);
  import srh_pkg::*;

  localparam int NREG = 2;

  logic [`SRH_HW_W-1:0] hw_in [NREG];
  logic [`SRH_PART_W-1:0] live_part [NREG];
  logic [`SRH_PART_W-1:0] rise_part [NREG];
  logic [`SRH_PART_W-1:0] fall_part [NREG];
  logic [`SRH_PART_W-1:0] latch_part [NREG];
  logic [`SRH_PART_W-1:0] mask_part [NREG];
  logic [NREG-1:0] reg_summary;

  logic [`SRH_STB_W-1:0] std_latch;
  logic [`SRH_STB_W-1:0] std_mask;
  logic [`SRH_STB_W-1:0] req_mask;
  logic [`SRH_STB_W-1:0] stb_base;
  logic [`SRH_STB_W-1:0] req_mask_eff;
  logic standard_summary_flag;
  logic request_summary_flag;
  logic questionable_summary_flag;
  logic operation_summary_flag;
  logic reply_waiting_flag;
  logic errq_not_empty;

  logic [`SRH_ERR_W-1:0] errq_mem [`SRH_ERRQ_DEPTH];
  logic [`SRH_ERRQ_AW-1:0] errq_wr_ptr;
  logic [`SRH_ERRQ_AW-1:0] errq_rd_ptr;
  logic [`SRH_ERRQ_CW-1:0] errq_count;
  logic errq_pop;
  logic errq_push;

  logic [`SRH_STB_W-1:0] std_unused_mask;
  logic [`SRH_PART_W-1:0] part_top_mask;

  assign std_unused_mask = ~(8'h01 << `SRH_STD_UNUSED);
  assign part_top_mask = ~(16'h0001 << `SRH_PART_TOP);

  // Hardware feeds the questionable and operation live parts
  assign hw_in[SRH_SEL_QUESTIONABLE_SUMMARY_FLAG] = questionable_summary_flag_status;
  assign hw_in[SRH_SEL_OPERATION_SUMMARY_FLAG] = operation_summary_flag_status;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : gen_reg
      logic [`SRH_PART_W-1:0] next_live;
      logic [`SRH_PART_W-1:0] rose;
      logic [`SRH_PART_W-1:0] fell;
      logic hit;
      logic latch_rd;

      assign next_live = {1'b0, hw_in[g]};
      assign rose = next_live & ~live_part[g];
      assign fell = ~next_live & live_part[g];
      assign hit = cmd_valid && (cmd_sel == srh_sel_t'(g));
      assign latch_rd = hit && (cmd_op == SRH_OP_LATCH_READ);

      // Live part has no write path; it follows the hardware input every cycle and reset clears it
      always_ff @(posedge clock) begin
        if (srst) begin
          live_part[g] <= 16'h0000;
        end else begin
          live_part[g] <= next_live;
        end
      end

      always_ff @(posedge clock) begin
        if (srst) begin
          rise_part[g] <= `SRH_RISE_RESET & part_top_mask;
          fall_part[g] <= `SRH_FALL_RESET;
          mask_part[g] <= `SRH_MASK_RESET;
        end else if (hit) begin
          if (cmd_op == SRH_OP_RISE_WRITE) begin
            rise_part[g] <= cmd_wdata & part_top_mask;
          end
          if (cmd_op == SRH_OP_FALL_WRITE) begin
            fall_part[g] <= cmd_wdata & part_top_mask;
          end
          if (cmd_op == SRH_OP_MASK_WRITE) begin
            mask_part[g] <= cmd_wdata & part_top_mask;
          end
        end
      end

      // A filtered change in the read cycle survives the clear
      always_ff @(posedge clock) begin
        if (srst) begin
          latch_part[g] <= 16'h0000;
        end else begin
          latch_part[g] <= ((latch_rd ? 16'h0000 : latch_part[g])
                            | (rose & rise_part[g])
                            | (fell & fall_part[g])) & part_top_mask;
        end
      end

      assign reg_summary[g] = |(latch_part[g] & mask_part[g]);
    end
  endgenerate

  assign questionable_summary_flag = reg_summary[SRH_SEL_QUESTIONABLE_SUMMARY_FLAG];
  assign operation_summary_flag = reg_summary[SRH_SEL_OPERATION_SUMMARY_FLAG];
  assign reply_waiting_flag = reply_waiting;

  // Standard latch register with its mask
  always_ff @(posedge clock) begin
    if (srst) begin
      std_latch <= 8'h00;
    end else begin
      std_latch <= ((cmd_valid && cmd_op == SRH_OP_STD_READ) ? 8'h00
                    : std_latch)
                   | (std_event_set & std_unused_mask);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      std_mask <= `SRH_ESE_RESET;
      req_mask <= `SRH_SRE_RESET;
    end else if (cmd_valid) begin
      if (cmd_op == SRH_OP_STDM_WRITE) begin
        std_mask <= cmd_wdata[`SRH_STB_W-1:0];
      end
      if (cmd_op == SRH_OP_SRE_WRITE) begin
        req_mask <= cmd_wdata[`SRH_STB_W-1:0];
      end
    end
  end

  // A rising masked standard bit is a new latched bit, so the summary rises
  assign standard_summary_flag = |(std_latch & std_mask);

  always_comb begin
    stb_base = 8'h00;
    stb_base[`SRH_STB_ERRQ] = errq_not_empty;
    stb_base[`SRH_STB_QUESTIONABLE_SUMMARY_FLAG] = questionable_summary_flag;
    stb_base[`SRH_STB_REPLY] = reply_waiting_flag;
    stb_base[`SRH_STB_STD] = standard_summary_flag;
    stb_base[`SRH_STB_OPERATION_SUMMARY_FLAG] = operation_summary_flag;
  end

  // Bits 0, 1 and 6 never count toward the request
  assign req_mask_eff = req_mask & 8'hBC;
  assign request_summary_flag = |(stb_base & req_mask_eff);

  always_comb begin
    status_byte = stb_base;
    status_byte[`SRH_STB_MSS] = request_summary_flag;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      service_request <= 1'b0;
    end else begin
      service_request <= request_summary_flag;
    end
  end

  // Error queue: circular store, oldest entry read first
  assign errq_not_empty = (errq_count != 4'h0);
  assign err_full = (errq_count == 4'(`SRH_ERRQ_DEPTH));
  assign errq_pop = cmd_valid && (cmd_op == SRH_OP_ERR_READ)
                    && errq_not_empty;
  // A push into a full queue is dropped unless a read frees a slot
  assign errq_push = err_push && (!err_full || errq_pop);

  always_ff @(posedge clock) begin
    if (errq_push) begin
      errq_mem[errq_wr_ptr] <= err_code;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      errq_wr_ptr <= 3'h0;
      errq_rd_ptr <= 3'h0;
      errq_count <= 4'h0;
    end else begin
      if (errq_push) begin
        errq_wr_ptr <= errq_wr_ptr + 3'h1;
      end
      if (errq_pop) begin
        errq_rd_ptr <= errq_rd_ptr + 3'h1;
      end
      if (errq_push && !errq_pop) begin
        errq_count <= errq_count + 4'h1;
      end else if (errq_pop && !errq_push) begin
        errq_count <= errq_count - 4'h1;
      end
    end
  end

  // Answers are registered, one cycle after the command
  always_ff @(posedge clock) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= cmd_valid;
      if (cmd_valid) begin
        case (cmd_op)
          SRH_OP_STB_QUERY: rsp_data <= {8'h00, status_byte};
          SRH_OP_SRE_READ: rsp_data <= {8'h00, req_mask};
          SRH_OP_STD_READ: rsp_data <= {8'h00, std_latch};
          SRH_OP_STDM_READ: rsp_data <= {8'h00, std_mask};
          SRH_OP_ERR_READ: begin
            rsp_data <= errq_not_empty ? errq_mem[errq_rd_ptr]
                                       : 16'h0000;
          end
          SRH_OP_LIVE_READ: rsp_data <= live_part[cmd_sel];
          SRH_OP_RISE_READ: rsp_data <= rise_part[cmd_sel];
          SRH_OP_FALL_READ: rsp_data <= fall_part[cmd_sel];
          SRH_OP_LATCH_READ: rsp_data <= latch_part[cmd_sel];
          SRH_OP_MASK_READ: rsp_data <= mask_part[cmd_sel];
          default: rsp_data <= 16'h0000;
        endcase
      end
    end
  end

  // Serial poll has its own path so it never waits behind a command
  always_ff @(posedge clock) begin
    if (srst) begin
      poll_valid <= 1'b0;
      poll_data <= 8'h00;
    end else begin
      poll_valid <= poll_req;
      if (poll_req) begin
        poll_data <= status_byte;
      end
    end
  end

endmodule

// *** sim/srh_core_asserts.sv ***
// Purpose: Port checker for the status core
// Assumes: One clock, srst synchronous active high
// Notes: Bound to every core instance
`timescale 1ns/100ps
`include "srh_cfg.svh"
module srh_core_asserts (
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire srh_pkg::srh_op_t cmd_op,
  input wire logic rsp_valid,
  input wire logic [`SRH_PART_W-1:0] rsp_data,
  input wire logic poll_req,
  input wire logic poll_valid,
  input wire logic [`SRH_STB_W-1:0] poll_data,
  input wire logic err_push,
  input wire logic reply_waiting,
  input wire logic [`SRH_STB_W-1:0] status_byte,
  input wire logic service_request
);
  import srh_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_take(srh_op_t op);
    cmd_valid && cmd_op == op;
  endsequence
  a_rsp_pulse: assert property (rsp_valid == $past(cmd_valid))
    else $error("response strobe out of step");
  a_write_zero: assert property (s_take(SRH_OP_MASK_WRITE) |=>
    rsp_data == '0) else $error("write answer not zero");
  a_live_top: assert property (s_take(SRH_OP_LIVE_READ) |=>
    !rsp_data[`SRH_PART_TOP]) else $error("live top bit set");
  a_stb_query: assert property (s_take(SRH_OP_STB_QUERY) |=>
    rsp_data == {8'h00, $past(status_byte)}) else $error("query wrong");
  a_poll_data: assert property (poll_req |=> poll_valid &&
    poll_data == $past(status_byte)) else $error("poll answer wrong");
  a_low_zero: assert property (status_byte[1:0] == 2'b00)
    else $error("unused status bits set");
  a_reply_bit: assert property (status_byte[4] == reply_waiting)
    else $error("reply bit wrong");
  a_err_flag: assert property (err_push |=> status_byte[2])
    else $error("error queue bit not set");
  a_srq_level: assert property (service_request == $past(status_byte[6]))
    else $error("request level wrong");
  a_srq_rise: assert property ($rose(status_byte[6]) |=>
    $rose(service_request)) else $error("request not raised");
endmodule
bind srh_status_core srh_core_asserts chk_u (.clock, .srst, .cmd_valid,
  .cmd_op, .rsp_valid, .rsp_data, .poll_req, .poll_valid, .poll_data,
  .err_push, .reply_waiting, .status_byte, .service_request);

// *** sim/srh_host_model.sv ***
// Purpose: Remote controller stand-in that polls on service request
// Assumes: The request is a level held until the cause clears
// Notes: LAG adds idle cycles before each poll to model a slow host
`timescale 1ns/100ps
`include "srh_cfg.svh"
module srh_host_model #(
  parameter int LAG = 0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic service_request,
  input wire logic poll_valid,
  input wire logic [`SRH_STB_W-1:0] poll_data,
  output logic poll_req,
  output logic [`SRH_STB_W-1:0] last_poll,
  output int polls
);
  initial begin
    poll_req = 1'b0;
    last_poll = 8'h00;
    polls = 0;
    forever begin
      @(posedge clock);
      #1;
      if (!srst && service_request) begin
        repeat (LAG) @(posedge clock);
        #1 poll_req = 1'b1;
        @(posedge clock);
        #1 poll_req = 1'b0;
        if (poll_valid) begin
          last_poll = poll_data;
          polls++;
        end
        // Poll once per request, not once per cycle
        wait (!service_request);
      end
    end
  end
endmodule

// *** sim/tb_status_reporting_hierarchy.sv ***
// Purpose: Self-checking bench for the status core
// Assumes: Host model answers service requests by serial poll
// Notes: Expected values come from a small integer model
`timescale 1ns/100ps
`include "srh_cfg.svh"
module tb_status_reporting_hierarchy;
  import srh_pkg::*;
  logic clock, rsp_valid, poll_req, poll_valid, err_full, service_request;
  logic srst = 1'b1, cmd_valid = 1'b0, err_push = 1'b0;
  logic reply_waiting = 1'b0;
  srh_op_t cmd_op = SRH_OP_STB_QUERY;
  srh_sel_t cmd_sel = SRH_SEL_QUESTIONABLE_SUMMARY_FLAG;
  logic [15:0] cmd_wdata = '0, err_code = '0, lfsr = 16'h0022, rsp_data;
  logic [14:0] questionable_summary_flag_status = '0, operation_summary_flag_status = '0;
  logic [7:0] std_event_set = '0, poll_data, status_byte, last_poll;
  int error_cnt, compares, polls, w, s;
  int m_rise[2] = '{32'h7FFF, 32'h7FFF}, m_fall[2], m_latch[2], m_live[2];
  int errq[$];

  srh_status_core dut_u (.clock, .srst, .cmd_valid, .cmd_op, .cmd_sel,
    .cmd_wdata, .rsp_valid, .rsp_data, .poll_req, .poll_valid, .poll_data,
    .questionable_summary_flag_status, .operation_summary_flag_status, .std_event_set, .err_push, .err_code,
    .err_full, .reply_waiting, .status_byte, .service_request);
  srh_host_model host_u (.clock, .srst, .service_request, .poll_valid,
    .poll_data, .poll_req, .last_poll, .polls);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic c(input srh_op_t op, input int wd, input int exp);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_sel <= srh_sel_t'(s[0]);
    cmd_wdata <= 16'(wd);
    @(posedge clock);
    cmd_valid <= 1'b0;
    #1 chk({15'h0000, rsp_valid}, 16'h0001);
    chk(rsp_data, 16'(exp));
  endtask

  // Model moves first so the expected latch never lags the stimulus
  task automatic live(input logic [14:0] v);
    m_latch[s] |= (~m_live[s] & v & m_rise[s]) | (m_live[s] & ~v & m_fall[s]);
    m_live[s] = v;
    @(posedge clock);
    if (s == 1) operation_summary_flag_status <= v;
    else questionable_summary_flag_status <= v;
    repeat (2) @(posedge clock);
  endtask

  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    reply_waiting <= 1'b1;
    c(SRH_OP_SRE_WRITE, 32'h40, 0);
    chk(status_byte, 8'h10);
    c(SRH_OP_SRE_WRITE, 32'h10, 0);
    chk(status_byte, 8'h50);
    c(SRH_OP_STB_QUERY, 0, 32'h50);
    c(SRH_OP_SRE_WRITE, 0, 0);
    reply_waiting <= 1'b0;
    for (s = 0; s < 2; s++) begin
      c(SRH_OP_RISE_READ, 0, 32'h7FFF);
      c(SRH_OP_FALL_READ, 0, 0);
      c(SRH_OP_MASK_READ, 0, 0);
      w = rnd();
      c(SRH_OP_RISE_WRITE, w, 0);
      c(SRH_OP_RISE_READ, 0, w & 32'h7FFF);
      c(SRH_OP_RISE_WRITE, 1, 0);
      c(SRH_OP_FALL_WRITE, 2, 0);
      c(SRH_OP_FALL_READ, 0, 2);
      c(SRH_OP_MASK_WRITE, 1, 0);
      c(SRH_OP_MASK_READ, 0, 1);
      m_rise[s] = 1;
      m_fall[s] = 2;
      live(15'h0003);
      c(SRH_OP_LIVE_READ, 0, 3);
      chk(status_byte[s == 1 ? 7 : 3], 1);
      c(SRH_OP_SRE_WRITE, 32'hC8, 0);
      repeat (4) @(posedge clock);
      #1 chk(last_poll, s == 1 ? 8'hC0 : 8'h48);
      live(15'h0000);
      c(SRH_OP_LATCH_READ, 0, m_latch[s]);
      m_latch[s] = 0;
      c(SRH_OP_LATCH_READ, 0, 0);
      chk({status_byte[6], service_request}, 0);
      c(SRH_OP_SRE_WRITE, 0, 0);
    end
    c(SRH_OP_STDM_WRITE, 1, 0);
    c(SRH_OP_STDM_READ, 0, 1);
    @(posedge clock);
    std_event_set <= 8'h03;
    @(posedge clock);
    std_event_set <= 8'h00;
    #1 chk(status_byte[5], 1);
    c(SRH_OP_STD_READ, 0, 1);
    c(SRH_OP_STD_READ, 0, 0);
    for (int i = 0; i < 3; i++) begin
      w = rnd();
      errq.push_back(w);
      @(posedge clock);
      err_push <= 1'b1;
      err_code <= 16'(w);
      @(posedge clock);
      err_push <= 1'b0;
    end
    #1 chk(status_byte[2], 1);
    repeat (3) c(SRH_OP_ERR_READ, 0, errq.pop_front());
    c(SRH_OP_ERR_READ, 0, 0);
    // Nine pushes into eight slots: the last one must be dropped
    for (int i = 0; i < 9; i++) begin
      @(posedge clock);
      err_push <= 1'b1;
      err_code <= 16'(i);
      @(posedge clock);
      err_push <= 1'b0;
    end
    #1 chk(err_full, 1);
    for (int i = 0; i < 8; i++) c(SRH_OP_ERR_READ, 0, i);
    chk(err_full, 0);
    c(SRH_OP_ERR_READ, 0, 0);
    give_verdict();
  end
endmodule
